/* src/apvf_top.sv */
// Serial audio receiver, DC filter, boost, ramped volume, clipper, PWM and fault supervisor.
// Assumes link pins and fault sense lines are asynchronous; register port is on clk_i.
//
// Function
// R1 - Frame clock high carries left word, low carries right word.
// R2 - Accept bit clock at 32, 48 or 64 times the sample rate.
// R3 - Source starts a 24-bit word eight bit clocks after frame edge.
// R4 - Word LSB sits in last bit clock before frame edge; align there.
// R5 - Data MSB first, sampled on bit clock rising edge.
// R6 - Short words get zero-filled leading bits before entering the path.
// R7 - DC-removing high-pass filter always active in pin-configured mode.
// R8 - Register mode: path_control bit 7 set bypasses the high-pass filter.
// R9 - Detected output DC stops the power stage with a latching fault.
// R10 - Boost follows the filter; pin-configured mode uses plus six decibels.
// R11 - Volume code is 0xCF plus gain over half decibel, mute to +24 dB.
// R12 - Applied volume steps half a decibel every eight frames toward target.
// R13 - Volume config bit 7 disables the fade; new volume applies at once.
// R14 - Clipper limits signal to a programmed 20-bit clip level.
// R15 - Each channel drives one complementary PWM output pair.
// R16 - PWM frequency is a configurable integer multiple of the sample rate.
// R17 - Six fault kinds each reported on fault pin and own status bit; under and over voltage leave the pin high.
// R18 - Latching faults clear only by toggling shutdown pin or bit.
// R19 - Fault still present at shutdown release re-enters fault state.
// R20 - Cleared latching fault resumes after toggle and the fault timeout.
// R21 - Non-latching faults resume playback automatically once cleared.
// R22 - Non-latching faults leave fault pin high, except clock errors.
// R23 - Fault pin is open-drain, active low, only ever pulled low.
// R24 - DC error: duty above 60 percent same polarity over 420 ms.
// R25 - Shutdown pin low shuts the amplifier, high releases it.
// R26 - Fault timeout length is a parameter in device clock cycles.
`timescale 1ns/1ps
`default_nettype none
module apvf_top #(
	parameter int unsigned DC_CYCLES = 32'(apvf_pkg::DC_CYCLES),
	parameter int unsigned FAULT_TIMEOUT = apvf_pkg::FAULT_TIMEOUT_DEF
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic hw_mode_i,
	input wire logic sclk_i,
	input wire logic lrck_i,
	input wire logic sdata_i,
	input wire logic amp_shutdown_n_i,
	input wire logic over_current_i,
	input wire logic under_voltage_i,
	input wire logic over_voltage_i,
	input wire logic over_temp_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic [1:0] pwm_p_o,
	output logic [1:0] pwm_n_o,
	output logic amp_fault_n_o,
	output logic amp_fault_n_oe_o
);
	import apvf_pkg::*;

	logic [8:0] pin_s1, pin_s2;
	logic sclk_d, lrck_q;
	logic hw, sclk_s, lrck_s, sdata_s, sd_pin, oc, uv, ov, ot;
	logic [31:0] shreg;
	logic [5:0] bitcnt;
	logic [23:0] left_hold, word;
	logic [23:0] wmask;
	logic lr_edge, frame_tick, load;
	logic ratio_bad, stalled, clk_err;
	logic [12:0] stall_cnt;
	logic [11:0] flen_cnt, flen, period, pcnt;
	logic [7:0] power_r, path_r, pwm_r, vol_r, vcfg_r, err_r;
	logic [19:0] clip_r;
	logic [7:0] vol_now, vol_tgt;
	logic [2:0] fcnt;
	logic [15:0] gain;
	logic [1:0] boost_sel, pwm_sel;
	logic hpf_on, fade_on;
	logic [23:0] lim;
	apvf_pair_s fifo_mem [2];
	apvf_pair_s fifo_out;
	logic fifo_wp, fifo_rp;
	logic [1:0] fifo_cnt;
	logic in_ready, out_valid, out_ready, overrun;
	logic [1:0] dc_hit;
	logic sd_eff, latch_err, run;
	logic fault_pend;
	logic [22:0] tcnt;
	apvf_state_e state, next_state;

	function automatic logic [23:0] sat24(input logic signed [40:0] v);
		if (v > 41'sh7fffff) begin
			return 24'h7fffff;
		end
		if (v < -41'sh800000) begin
			return 24'h800000;
		end
		return v[23:0];
	endfunction

	// R11 code to gain
	function automatic logic [15:0] vol_gain(input logic [7:0] code);
		logic [7:0] k;
		logic [4:0] sh;
		logic [3:0] r;
		k = VOL_MAX_CODE - code;
		sh = 5'(k / 8'd12);
		r = 4'(k % 8'd12);
		if (code == VOL_MUTE) begin
			return 16'h0;
		end
		return GAIN_LUT[r] >> sh;
	endfunction

	// Pins cross into clk_i through two flops; the third sclk/lrck stage is for edges
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pin_s1 <= 9'h0;
			pin_s2 <= 9'h0;
			sclk_d <= 1'b0;
		end else begin
			pin_s1 <= {hw_mode_i, sclk_i, lrck_i, sdata_i, amp_shutdown_n_i,
				over_current_i, under_voltage_i, over_voltage_i, over_temp_i};
			pin_s2 <= pin_s1;
			sclk_d <= sclk_s;
		end
	end
	assign {hw, sclk_s, lrck_s, sdata_s, sd_pin, oc, uv, ov, ot} = pin_s2;

	// R5 sample on rise
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			shreg <= 32'h0;
			lrck_q <= 1'b0;
		end else if (sclk_s && !sclk_d) begin
			shreg <= {shreg[30:0], sdata_s};
			lrck_q <= lrck_s;
		end
	end

	// R4 word ends at frame edge
	assign lr_edge = sclk_s && !sclk_d && (lrck_s != lrck_q);
	always_comb begin
		unique case (path_r[PATH_WLEN_LSB +: 2])
			2'h0: wmask = 24'hffffff;
			2'h1: wmask = 24'h0fffff;
			2'h2: wmask = 24'h03ffff;
			2'h3: wmask = 24'h00ffff;
		endcase
		if (hw) begin
			wmask = 24'hffffff;
		end
	end
	// R6 zero leading bits
	// R3 last 24 bits kept
	assign word = shreg[23:0] & wmask;
	// R1 high is left
	assign frame_tick = lr_edge && lrck_s;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			left_hold <= 24'h0;
		end else if (lr_edge && lrck_q) begin
			left_hold <= word;
		end
	end

	// R2 ratio check
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			bitcnt <= 6'h0;
			ratio_bad <= 1'b0;
		end else if (lr_edge) begin
			bitcnt <= 6'h1;
			ratio_bad <= !(bitcnt == BITS_32X || bitcnt == BITS_48X || bitcnt == BITS_64X);
		end else if (sclk_s && !sclk_d && bitcnt != 6'h3f) begin
			bitcnt <= bitcnt + 6'h1;
		end
	end

	// A frame clock that stops is a clock error as well
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			stall_cnt <= 13'h0;
			stalled <= 1'b0;
		end else if (lr_edge) begin
			stall_cnt <= 13'h0;
			stalled <= 1'b0;
		end else if (stall_cnt == 13'(STALL_CYCLES)) begin
			stalled <= 1'b1;
		end else begin
			stall_cnt <= stall_cnt + 13'h1;
		end
	end
	assign clk_err = ratio_bad || stalled;

	// Frame length in clk cycles sets the PWM period
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			flen_cnt <= 12'h0;
			flen <= 12'h0;
			load <= 1'b0;
		end else begin
			load <= frame_tick;
			if (frame_tick) begin
				flen <= flen_cnt;
				flen_cnt <= 12'h1;
			end else if (flen_cnt != 12'hfff) begin
				flen_cnt <= flen_cnt + 12'h1;
			end
		end
	end

	// Two-entry buffer; stalls while run is low outside shutdown, so overrun is reported; shutdown flushes it
	assign in_ready = fifo_cnt != 2'h2;
	assign out_valid = fifo_cnt != 2'h0;
	assign out_ready = load && run;
	assign overrun = frame_tick && !in_ready;
	assign fifo_out = fifo_mem[fifo_rp];
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			fifo_wp <= 1'b0;
			fifo_rp <= 1'b0;
			fifo_cnt <= 2'h0;
		end else if (state == ST_SHUT) begin
			// R20 flush stale audio
			// A restart would otherwise replay the words that caused the fault
			fifo_wp <= 1'b0;
			fifo_rp <= 1'b0;
			fifo_cnt <= 2'h0;
		end else begin
			if (frame_tick && in_ready) begin
				fifo_mem[fifo_wp] <= '{left: left_hold, right: word};
				fifo_wp <= !fifo_wp;
			end
			if (out_valid && out_ready) begin
				fifo_rp <= !fifo_rp;
			end
			fifo_cnt <= fifo_cnt + 2'(frame_tick && in_ready) - 2'(out_valid && out_ready);
		end
	end

	// Register port
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			power_r <= POWER_RST;
			path_r <= PATH_RST;
			pwm_r <= PWM_RST;
			vol_r <= VOL_ZERO_DB;
			vcfg_r <= VCFG_RST;
			clip_r <= CLIP_RST;
		end else if (reg_wr_i) begin
			unique case (reg_addr_i)
				REG_POWER: power_r <= reg_wdata_i;
				REG_PATH: path_r <= reg_wdata_i;
				REG_PWM: pwm_r <= reg_wdata_i;
				REG_VOL: vol_r <= reg_wdata_i;
				REG_VCFG: vcfg_r <= reg_wdata_i;
				REG_CLIP0: clip_r[7:0] <= reg_wdata_i;
				REG_CLIP1: clip_r[15:8] <= reg_wdata_i;
				REG_CLIP2: clip_r[19:16] <= reg_wdata_i[3:0];
				default: ;
			endcase
		end
	end

	// R17 status bits, set wins over write-one clear
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			err_r <= 8'h0;
		end else begin
			err_r <= (err_r & ~((reg_wr_i && reg_addr_i == REG_ERR) ? reg_wdata_i : 8'h0))
				| 8'({overrun, clk_err, |dc_hit, ot, ov, uv, oc});
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h0;
		end else begin
			unique case (reg_addr_i)
				REG_POWER: reg_rdata_o <= power_r;
				REG_PATH: reg_rdata_o <= path_r;
				REG_PWM: reg_rdata_o <= pwm_r;
				REG_VOL: reg_rdata_o <= vol_r;
				REG_VCFG: reg_rdata_o <= vcfg_r;
				REG_CLIP0: reg_rdata_o <= clip_r[7:0];
				REG_CLIP1: reg_rdata_o <= clip_r[15:8];
				REG_CLIP2: reg_rdata_o <= {4'h0, clip_r[19:16]};
				REG_ERR: reg_rdata_o <= err_r;
				REG_VNOW: reg_rdata_o <= vol_now;
				default: reg_rdata_o <= 8'h0;
			endcase
		end
	end

	// Pin-configured mode ignores the path registers
	// R7 filter forced on
	// R8 bypass bit
	assign hpf_on = hw || !path_r[PATH_HPF_BYP];
	// R10 fixed boost
	assign boost_sel = hw ? HW_BOOST : path_r[PATH_BOOST_LSB +: 2];
	// R16 ratio select
	assign pwm_sel = hw ? HW_PWM_SEL : pwm_r[1:0];
	assign vol_tgt = hw ? VOL_ZERO_DB : vol_r;
	// R13 fade off
	assign fade_on = hw || !vcfg_r[VCFG_NOFADE];
	// R14 clip level
	assign lim = hw ? 24'h7fffff : {1'b0, clip_r, 3'h0};

	// R12 step every 8 frames
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			vol_now <= VOL_ZERO_DB;
			fcnt <= 3'h0;
		end else if (!fade_on) begin
			vol_now <= vol_tgt;
		end else if (frame_tick) begin
			fcnt <= fcnt + 3'h1;
			if (fcnt == VOL_STEP_FRAMES && vol_now < vol_tgt) begin
				vol_now <= vol_now + 8'h1;
			end else if (fcnt == VOL_STEP_FRAMES && vol_now > vol_tgt) begin
				vol_now <= vol_now - 8'h1;
			end
		end
	end
	assign gain = vol_gain(vol_now);

	// R16 period is frame over 2^n
	assign period = flen >> (PWM_SHIFT_BASE + int'(pwm_sel));
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pcnt <= 12'h0;
		end else if (frame_tick || pcnt + 12'h1 >= period) begin
			pcnt <= 12'h0;
		end else begin
			pcnt <= pcnt + 12'h1;
		end
	end

	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		logic [23:0] x, xp, yp, hp, bo, vo, cl, samp;
		logic [11:0] duty;
		logic [35:0] prod;
		logic [1:0] pol, pol_q;
		logic [24:0] dcnt;

		assign x = (ch == 0) ? fifo_out.left : fifo_out.right;
		// R7 first-order DC removal
		assign hp = hpf_on ? sat24(41'(signed'(x)) - 41'(signed'(xp)) + 41'(signed'(yp))
			- 41'(signed'(yp) >>> HPF_SHIFT)) : x;
		// R10 boost shift
		assign bo = sat24(41'(signed'(hp)) <<< boost_sel);
		// R11 apply gain
		assign vo = sat24((41'(signed'(bo)) * 41'(signed'({1'b0, gain}))) >>> GAIN_FRAC);
		// R14 clip
		always_comb begin
			cl = vo;
			if ($signed(vo) > $signed(lim)) begin
				cl = lim;
			end else if ($signed(vo) < -$signed(lim)) begin
				cl = 24'(-$signed(lim));
			end
		end

		always_ff @(posedge clk_i) begin
			if (!rst_n_i) begin
				xp <= 24'h0;
				yp <= 24'h0;
				samp <= 24'h0;
			end else if (state == ST_SHUT) begin
				// R20 clear held samples
				xp <= 24'h0;
				yp <= 24'h0;
				samp <= 24'h0;
			end else if (out_valid && out_ready) begin
				xp <= x;
				yp <= hp;
				samp <= cl;
			end
		end

		assign prod = 36'(samp ^ 24'h800000) * 36'(period);
		assign duty = prod[35:24];

		// R15 complementary pair
		always_ff @(posedge clk_i) begin
			if (!rst_n_i) begin
				pwm_p_o[ch] <= 1'b0;
				pwm_n_o[ch] <= 1'b0;
			end else begin
				pwm_p_o[ch] <= run && (pcnt < duty);
				pwm_n_o[ch] <= run && !(pcnt < duty);
			end
		end

		// R24 duty over 60 percent, same polarity
		assign pol = {15'(duty) * 15'd5 < 15'(period) * 15'd2,
			15'(duty) * 15'd5 > 15'(period) * 15'd3};
		always_ff @(posedge clk_i) begin
			if (!rst_n_i) begin
				dcnt <= 25'h0;
				pol_q <= 2'h0;
			end else begin
				pol_q <= pol;
				if (!run || pol == 2'h0 || pol != pol_q) begin
					dcnt <= 25'h0;
				end else if (dcnt <= 25'(DC_CYCLES)) begin
					dcnt <= dcnt + 25'h1;
				end
			end
		end
		assign dc_hit[ch] = dcnt > 25'(DC_CYCLES);
	end

	// R25 pin low shuts down
	// R18 pin or bit toggle
	assign sd_eff = sd_pin && (hw || power_r[POWER_SD_BIT]);
	// R9 DC is latching
	assign latch_err = oc || ot || (|dc_hit);
	// R21 auto resume
	assign run = (state == ST_RUN) && !uv && !ov && !clk_err;

	always_comb begin
		next_state = state;
		unique case (state)
			ST_SHUT: begin
				// R19 re-fault on release
				if (sd_eff && latch_err) begin
					next_state = ST_FAULT;
				end else if (sd_eff && fault_pend) begin
					next_state = ST_WAIT;
				end else if (sd_eff) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!sd_eff) begin
					next_state = ST_SHUT;
				end else if (latch_err) begin
					next_state = ST_FAULT;
				end
			end
			ST_FAULT: begin
				if (!sd_eff) begin
					next_state = ST_SHUT;
				end
			end
			ST_WAIT: begin
				if (!sd_eff) begin
					next_state = ST_SHUT;
				end else if (latch_err) begin
					next_state = ST_FAULT;
				end else if (tcnt == 23'(FAULT_TIMEOUT - 1)) begin
					// R20 resume after timeout
					next_state = ST_RUN;
				end
			end
			default: next_state = ST_SHUT;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state <= ST_SHUT;
		end else begin
			state <= next_state;
		end
	end

	// R26 timeout counter
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			tcnt <= 23'h0;
			fault_pend <= 1'b0;
		end else begin
			tcnt <= (state == ST_WAIT) ? tcnt + 23'h1 : 23'h0;
			if (state == ST_FAULT) begin
				fault_pend <= 1'b1;
			end else if (state == ST_WAIT && next_state == ST_RUN) begin
				fault_pend <= 1'b0;
			end
		end
	end

	// R22 clock error pulls low
	// R23 open drain, drive low only
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			amp_fault_n_oe_o <= 1'b0;
		end else begin
			amp_fault_n_oe_o <= (state == ST_FAULT) || (state == ST_WAIT) || clk_err;
		end
	end
	assign amp_fault_n_o = 1'b0;
endmodule
`default_nettype wire

/* pkg/apvf_pkg.sv */
// Shared constants, types and register map of the audio path, volume and fault block.
// Assumes a single 40 MHz device clock; all link pins are asynchronous to it.
package apvf_pkg;
	localparam logic [7:0] REG_POWER = 8'h01;
	localparam logic [7:0] REG_PATH = 8'h02;
	localparam logic [7:0] REG_PWM = 8'h03;
	localparam logic [7:0] REG_VOL = 8'h04;
	localparam logic [7:0] REG_VCFG = 8'h05;
	localparam logic [7:0] REG_CLIP0 = 8'h06;
	localparam logic [7:0] REG_CLIP1 = 8'h07;
	localparam logic [7:0] REG_CLIP2 = 8'h08;
	localparam logic [7:0] REG_ERR = 8'h09;
	localparam logic [7:0] REG_VNOW = 8'h0a;

	localparam int POWER_SD_BIT = 0;
	localparam int PATH_HPF_BYP = 7;
	localparam int PATH_WLEN_LSB = 2;
	localparam int PATH_BOOST_LSB = 0;
	localparam int VCFG_NOFADE = 7;

	localparam logic [7:0] POWER_RST = 8'h01;
	localparam logic [7:0] PATH_RST = 8'h01;
	localparam logic [7:0] PWM_RST = 8'h01;
	localparam logic [7:0] VOL_ZERO_DB = 8'hcf;
	localparam logic [7:0] VOL_MUTE = 8'h00;
	localparam logic [7:0] VOL_MAX_CODE = 8'hff;
	localparam logic [7:0] VCFG_RST = 8'h00;
	localparam logic [19:0] CLIP_RST = 20'hfffff;
	localparam logic [1:0] HW_BOOST = 2'h1;
	localparam logic [1:0] HW_PWM_SEL = 2'h1;

	localparam int ERR_OC = 0;
	localparam int ERR_UV = 1;
	localparam int ERR_OV = 2;
	localparam int ERR_OT = 3;
	localparam int ERR_DC = 4;
	localparam int ERR_CK = 5;
	localparam int ERR_OVR = 6;

	localparam longint CLK_HZ = 40_000_000;
	localparam longint DC_TIME_MS = 420;
	localparam longint DC_CYCLES = (DC_TIME_MS * CLK_HZ + 999) / 1000;
	localparam longint STALL_TIME_US = 100;
	localparam int STALL_CYCLES = int'(STALL_TIME_US * CLK_HZ / 1_000_000);
	localparam int FAULT_TIMEOUT_DEF = 4_000_000;

	localparam logic [5:0] BITS_32X = 6'h10;
	localparam logic [5:0] BITS_48X = 6'h18;
	localparam logic [5:0] BITS_64X = 6'h20;
	localparam logic [2:0] VOL_STEP_FRAMES = 3'h7;
	localparam int HPF_SHIFT = 10;
	localparam int GAIN_FRAC = 12;
	localparam int PWM_SHIFT_BASE = 3;
	localparam logic [15:0] GAIN_LUT [12] = '{16'hfd95, 16'hef68, 16'he204, 16'hd55e,
		16'hc96d, 16'hbe29, 16'hb382, 16'ha978, 16'ha002, 16'h970f, 16'h8e97, 16'h86a1};

	typedef struct packed {
		logic [23:0] left;
		logic [23:0] right;
	} apvf_pair_s;

	typedef enum logic [3:0] {
		ST_SHUT = 4'b0001,
		ST_RUN = 4'b0010,
		ST_FAULT = 4'b0100,
		ST_WAIT = 4'b1000
	} apvf_state_e;
endpackage

/* verification/apvf_top_asserts.sv */
// Concurrent checks on the ports of the audio path, volume and fault block.
// Assumes the bind below; all watched signals are on clk_i.
`timescale 1ns/1ps
`default_nettype none
module apvf_top_asserts #(
	parameter int unsigned DC_CYCLES = 200,
	parameter int unsigned FAULT_TIMEOUT = 50
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic amp_shutdown_n_i,
	input wire logic over_current_i,
	input wire logic under_voltage_i,
	input wire logic over_voltage_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [1:0] pwm_p_o,
	input wire logic [1:0] pwm_n_o,
	input wire logic amp_fault_n_o,
	input wire logic amp_fault_n_oe_o
);
	import apvf_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic quiet;
	assign quiet = pwm_p_o == 2'h0 && pwm_n_o == 2'h0;
	pin_never_high_a: assert property (amp_fault_n_o == 1'b0)
		else $error("fault pin data not low");
	pwm_pair_excl_a: assert property ((pwm_p_o & pwm_n_o) == 2'h0)
		else $error("pwm pair both high");
	reset_quiet_a: assert property ($rose(rst_n_i) |-> quiet && !amp_fault_n_oe_o && !reg_rdata_o)
		else $error("outputs not quiet after reset");
	shut_stops_pwm_a: assert property (!amp_shutdown_n_i [*6] |-> quiet)
		else $error("pwm runs in shutdown");
	oc_raises_pin_a: assert property ($rose(over_current_i) && amp_shutdown_n_i
		|-> ##[1:8] amp_fault_n_oe_o)
		else $error("over current not reported");
	nonlatch_stop_a: assert property ((under_voltage_i || over_voltage_i) [*6] |-> quiet)
		else $error("pwm runs on supply fault");
	fault_stops_pwm_a: assert property (amp_fault_n_oe_o [*3] |-> quiet)
		else $error("pwm runs while fault pulled");
	vol_readback_a: assert property (reg_wr_i && reg_addr_i == REG_VOL ##1
		!reg_wr_i && reg_addr_i == REG_VOL |=> reg_rdata_o == $past(reg_wdata_i, 2))
		else $error("volume readback wrong");
endmodule
bind apvf_top apvf_top_asserts #(.DC_CYCLES(DC_CYCLES), .FAULT_TIMEOUT(FAULT_TIMEOUT)) i_chk (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .amp_shutdown_n_i(amp_shutdown_n_i),
	.over_current_i(over_current_i), .under_voltage_i(under_voltage_i),
	.over_voltage_i(over_voltage_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
	.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .pwm_p_o(pwm_p_o), .pwm_n_o(pwm_n_o),
	.amp_fault_n_o(amp_fault_n_o), .amp_fault_n_oe_o(amp_fault_n_oe_o));
`default_nettype wire

/* verification/apvf_src_model.sv */
// Upstream serial audio source sending right-aligned 24-bit words.
// Assumes the bench sets the half-frame length; bit clock stops while disabled.
`timescale 1ns/1ps
`default_nettype none
module apvf_src_model (
	input wire logic en_i,
	input wire logic [5:0] bits_i,
	input wire logic [23:0] left_i,
	input wire logic [23:0] right_i,
	output logic sclk_o,
	output logic lrck_o,
	output logic sdata_o
);
	logic [23:0] w;
	int n;
	initial begin
		sclk_o = 1'b0;
		lrck_o = 1'b0;
		sdata_o = 1'b0;
		forever begin
			wait (en_i);
			n = bits_i;
			for (int h = 1; h >= 0; h--) begin
				lrck_o = h[0];
				w = h ? left_i : right_i;
				for (int i = n - 1; i >= 0; i--) begin
					sdata_o = (i < 24) ? w[i] : ~i[0];
					#100 sclk_o = 1'b1;
					#100 sclk_o = 1'b0;
				end
			end
			// Idle data must not look like a held bit
			if (!en_i) sdata_o = ~sdata_o;
		end
	end
endmodule
`default_nettype wire

/* verification/tb_audio_path_volume_fault.sv */
// Self-checking bench for apvf_top with a serial source model.
// Assumes short DC and timeout counts; fault net has a pull-up here.
`timescale 1ns/1ps
`default_nettype none
module tb_audio_path_volume_fault;
	import apvf_pkg::*;
	localparam int unsigned DCC = 200;
	localparam int unsigned FTO = 50;
	logic clk_i = 1'b0, rst_n_i = 1'b0, shut_n = 1'b1, oc = 1'b0, uv = 1'b0, ov = 1'b0;
	logic ot = 1'b0, wr = 1'b0, en = 1'b0, hwm = 1'b0, pq = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
	logic [1:0] pp, pn;
	logic fo, foe, fnet, sclk, lrck, sdata;
	logic [5:0] bits = BITS_32X;
	logic [23:0] left = 24'h000000, right = 24'h000000;
	int errors = 0, checks = 0, cyc = 0, cl, cr, act, bad, eg;
	always #12.5 clk_i = ~clk_i;
	assign fnet = foe ? fo : 1'b1;
	apvf_top #(.DC_CYCLES(DCC), .FAULT_TIMEOUT(FTO)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.hw_mode_i(hwm), .sclk_i(sclk), .lrck_i(lrck), .sdata_i(sdata), .amp_shutdown_n_i(shut_n),
		.over_current_i(oc), .under_voltage_i(uv), .over_voltage_i(ov), .over_temp_i(ot),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .pwm_p_o(pp),
		.pwm_n_o(pn), .amp_fault_n_o(fo), .amp_fault_n_oe_o(foe));
	apvf_src_model i_src (.en_i(en), .bits_i(bits), .left_i(left), .right_i(right),
		.sclk_o(sclk), .lrck_o(lrck), .sdata_o(sdata));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic cyc_n(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk_i);
		addr = a;
		wdata = v;
		wr = 1'b1;
		@(negedge clk_i);
		wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(negedge clk_i);
		addr = a;
		@(negedge clk_i);
		d = rdata;
	endtask
	task automatic frames(input int n);
		repeat (n) @(posedge lrck);
		@(negedge clk_i);
	endtask
	task automatic toggle_shut;
		cyc_n(1);
		shut_n = 1'b0;
		cyc_n(10);
		shut_n = 1'b1;
	endtask
	// Duty and activity of the pwm pairs over a window
	task automatic measure(input int n);
		cl = 0;
		cr = 0;
		act = 0;
		bad = 0;
		eg = 0;
		repeat (n) begin
			@(negedge clk_i);
			cl += pp[0];
			cr += pp[1];
			act += (pp != 2'h0);
			bad += (pn !== ~pp);
			eg += (pp[0] != pq);
			pq = pp[0];
		end
	endtask
	task automatic t_regs;
		rd_reg(REG_PATH);
		chk("path reset", d, PATH_RST);
		rd_reg(REG_VCFG);
		chk("vcfg reset", d, VCFG_RST);
		rd_reg(8'h30);
		chk("unmapped", d, 8'h00);
		wr_reg(REG_PATH, 8'h80);
		rd_reg(REG_PATH);
		chk("bypass bit", d, 8'h80);
	endtask
	task automatic t_ratio;
		logic [5:0] r [3] = '{BITS_32X, BITS_48X, BITS_64X};
		for (int k = 0; k < 3; k++) begin
			bits = r[k];
			frames(4);
			wr_reg(REG_ERR, 8'h7f);
			frames(2);
			rd_reg(REG_ERR);
			chk("ratio err", d[ERR_CK], 1'b0);
			chk("ratio pin", fnet, 1'b1);
		end
		bits = 6'h14;
		frames(4);
		rd_reg(REG_ERR);
		chk("clk err bit", d[ERR_CK], 1'b1);
		chk("clk err pin", fnet, 1'b0);
		bits = BITS_64X;
		frames(4);
		chk("clk err gone", fnet, 1'b1);
		wr_reg(REG_ERR, 8'h7f);
	endtask
	task automatic t_volume;
		wr_reg(REG_VCFG, 8'h80);
		wr_reg(REG_VOL, VOL_ZERO_DB);
		rd_reg(REG_VOL);
		chk("vol code", d, VOL_ZERO_DB);
		rd_reg(REG_VNOW);
		chk("no fade", d, VOL_ZERO_DB);
		wr_reg(REG_VCFG, VCFG_RST);
		wr_reg(REG_VOL, VOL_ZERO_DB + 8'h04);
		frames(2);
		rd_reg(REG_VNOW);
		chk("fade step", d <= VOL_ZERO_DB + 8'h01, 1'b1);
		frames(40);
		rd_reg(REG_VNOW);
		chk("fade end", d, VOL_ZERO_DB + 8'h04);
	endtask
	task automatic t_channel;
		int c0, e0;
		left = 24'h080000;
		right = 24'hf80000;
		frames(3);
		measure(3000);
		chk("left wider", cl > cr, 1'b1);
		chk("complement", bad, 0);
		c0 = cl;
		e0 = eg;
		wr_reg(REG_PATH, 8'h81);
		frames(3);
		measure(3000);
		chk("boost", cl > c0, 1'b1);
		c0 = cl;
		// Sixteen-bit words: the set leading bits of the left word must vanish
		wr_reg(REG_PATH, 8'h8d);
		frames(3);
		measure(3000);
		chk("zero fill", cl < c0, 1'b1);
		wr_reg(REG_PATH, 8'h81);
		wr_reg(REG_PWM, 8'h00);
		frames(3);
		measure(3000);
		chk("pwm rate", eg * 3 < e0 * 2, 1'b1);
		hwm = 1'b1;
		frames(3);
		measure(3000);
		chk("pin mode rate", eg * 3 > e0 * 2, 1'b1);
		hwm = 1'b0;
	endtask
	task automatic t_dc;
		wr_reg(REG_CLIP0, 8'h00);
		wr_reg(REG_CLIP1, 8'h00);
		wr_reg(REG_CLIP2, 8'h00);
		left = 24'h7fffff;
		right = 24'h000000;
		frames(3);
		chk("clipped", fnet, 1'b1);
		wr_reg(REG_CLIP2, 8'h0f);
		wr_reg(REG_CLIP1, 8'hff);
		wr_reg(REG_CLIP0, 8'hff);
		frames(3);
		rd_reg(REG_ERR);
		chk("dc bit", d[ERR_DC], 1'b1);
		chk("dc pin", fnet, 1'b0);
		left = 24'h000000;
		frames(2);
		chk("dc held", fnet, 1'b0);
		toggle_shut;
		cyc_n(10);
		chk("timeout pin", fnet, 1'b0);
		cyc_n(FTO + 20);
		chk("dc resumed", fnet, 1'b1);
	endtask
	task automatic t_latch;
		wr_reg(REG_ERR, 8'h7f);
		oc = 1'b1;
		cyc_n(10);
		rd_reg(REG_ERR);
		chk("oc bit", d[ERR_OC], 1'b1);
		oc = 1'b0;
		cyc_n(100);
		chk("oc held", fnet, 1'b0);
		oc = 1'b1;
		toggle_shut;
		cyc_n(FTO + 20);
		chk("oc again", fnet, 1'b0);
		oc = 1'b0;
		wr_reg(REG_POWER, 8'h00);
		cyc_n(5);
		wr_reg(REG_POWER, POWER_RST);
		cyc_n(FTO + 20);
		chk("bit toggle", fnet, 1'b1);
	endtask
	task automatic t_nonlatch;
		for (int k = 0; k < 2; k++) begin
			frames(2);
			uv = k == 0;
			ov = k == 1;
			cyc_n(10);
			measure(200);
			chk("supply stop", act, 0);
			chk("supply pin", fnet, 1'b1);
			uv = 1'b0;
			ov = 1'b0;
			frames(1);
			measure(200);
			chk("supply resume", act > 0, 1'b1);
		end
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 100000) begin
			errors++;
			summarize;
		end
	end
	initial begin
		cyc_n(10);
		rst_n_i = 1'b1;
		en = 1'b1;
		t_regs;
		t_ratio;
		t_volume;
		t_channel;
		t_dc;
		t_latch;
		t_nonlatch;
		summarize;
	end
endmodule
`default_nettype wire
